// >>> verilog/fors_pkg.sv
// constants, state codes and register layout of the flash operation and reset sequencer
// assumes a 20 MHz core clock and a 16-bit register port owned by the host
package fors_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 50;

    // operation times in ns, typical figures, all inside the guaranteed maxima
    localparam int T_LOAD_SECT_NS  = 23000;
    localparam int T_LOAD_PAGE_NS  = 30000;
    localparam int T_PROG_SECT_NS  = 205000;
    localparam int T_PROG_PAGE_NS  = 220000;
    localparam int T_OTP_NS        = 500;
    localparam int T_LOCK_NS       = 500;
    localparam int T_SUSPEND_NS    = 400000;
    localparam int T_ERASE1_NS     = 1500000;
    localparam int T_ERASEN_NS     = 4000000;
    localparam int T_VERIFY_NS     = 70000;
    localparam int T_INT_LOW_NS    = 1000;
    localparam int T_POR_WAIT_NS   = 400000;
    localparam int T_BOOT_COPY_NS  = 70000;
    localparam int T_READY1_NS     = 5000;
    localparam int T_READY2_NS     = 10000;

    // cycle counts derived from the times
    localparam int CYC_LOAD_SECT = T_LOAD_SECT_NS / CLK_PERIOD_NS;
    localparam int CYC_LOAD_PAGE = T_LOAD_PAGE_NS / CLK_PERIOD_NS;
    localparam int CYC_PROG_SECT = T_PROG_SECT_NS / CLK_PERIOD_NS;
    localparam int CYC_PROG_PAGE = T_PROG_PAGE_NS / CLK_PERIOD_NS;
    localparam int CYC_OTP       = T_OTP_NS / CLK_PERIOD_NS;
    localparam int CYC_LOCK      = T_LOCK_NS / CLK_PERIOD_NS;
    localparam int CYC_SUSPEND   = T_SUSPEND_NS / CLK_PERIOD_NS;
    localparam int CYC_ERASE1    = T_ERASE1_NS / CLK_PERIOD_NS;
    localparam int CYC_ERASEN    = T_ERASEN_NS / CLK_PERIOD_NS;
    localparam int CYC_VERIFY    = T_VERIFY_NS / CLK_PERIOD_NS;
    localparam int CYC_INT_LOW   = T_INT_LOW_NS / CLK_PERIOD_NS;
    localparam int CYC_POR_WAIT  = T_POR_WAIT_NS / CLK_PERIOD_NS;
    localparam int CYC_BOOT_COPY = T_BOOT_COPY_NS / CLK_PERIOD_NS;
    localparam int CYC_READY1    = T_READY1_NS / CLK_PERIOD_NS;
    localparam int CYC_READY2    = T_READY2_NS / CLK_PERIOD_NS;
    localparam int TIMER_W       = 18;

    // register addresses
    localparam logic [15:0] ADDR_CMD    = 16'hF220;
    localparam logic [15:0] ADDR_CFG    = 16'hF221;
    localparam logic [15:0] ADDR_STATUS = 16'hF240;
    localparam logic [15:0] ADDR_INT    = 16'hF241;

    // boot partition windows
    localparam logic [15:0] BOOTP_LO_BASE = 16'h0000;
    localparam logic [15:0] BOOTP_LO_TOP  = 16'h01FF;
    localparam logic [15:0] BOOTP_HI_BASE = 16'h8000;
    localparam logic [15:0] BOOTP_HI_TOP  = 16'h800F;

    // command codes
    localparam logic [15:0] CMD_LOAD_SECT = 16'h0010;
    localparam logic [15:0] CMD_LOAD_PAGE = 16'h0011;
    localparam logic [15:0] CMD_PROG_SECT = 16'h0020;
    localparam logic [15:0] CMD_PROG_PAGE = 16'h0021;
    localparam logic [15:0] CMD_ERASE1    = 16'h0030;
    localparam logic [15:0] CMD_ERASEN    = 16'h0031;
    localparam logic [15:0] CMD_VERIFY    = 16'h0032;
    localparam logic [15:0] CMD_SUSPEND   = 16'h0033;
    localparam logic [15:0] CMD_RESUME    = 16'h0034;
    localparam logic [15:0] CMD_LOCK      = 16'h0040;
    localparam logic [15:0] CMD_OTP       = 16'h0050;
    localparam logic [15:0] CMD_BURST     = 16'h0060;
    localparam logic [15:0] CMD_RST_BP    = 16'h00F0;
    localparam logic [15:0] CMD_RST_HOT   = 16'h00F3;

    // configuration fields and reset value
    localparam int          CFG_AUTO_BIT = 0;
    localparam int          CFG_POL_BIT  = 1;
    localparam int          CFG_OE_BIT   = 2;
    localparam logic [2:0]  CFG_RESET    = 3'h6;

    // status fields
    localparam int STAT_INT_BIT   = 0;
    localparam int STAT_BUSY_BIT  = 1;
    localparam int STAT_BOOT_BIT  = 2;
    localparam int STAT_READY_BIT = 3;
    localparam int STAT_SUSP_BIT  = 4;

    typedef enum logic [7:0] {
        ST_POR_WAIT  = 8'h01,
        ST_BOOT_COPY = 8'h02,
        ST_RESET     = 8'h04,
        ST_IDLE      = 8'h08,
        ST_OP        = 8'h10,
        ST_ERASE     = 8'h20,
        ST_SUSP_GO   = 8'h40,
        ST_SUSPENDED = 8'h80
    } fors_state_t;

endpackage

// >>> verilog/fors_sequencer.sv
// flash operation and reset sequencer: operation timers, completion flag, boot copy, resets
// assumes host-side strobes synchronous to clock and a host that paces its own page programs
`timescale 1ns/1ps
`default_nettype none

module fors_sequencer #(
    parameter int PROG_SECT_CYC = fors_pkg::CYC_PROG_SECT,
    parameter int PROG_PAGE_CYC = fors_pkg::CYC_PROG_PAGE,
    parameter int SUSPEND_CYC   = fors_pkg::CYC_SUSPEND,
    parameter int ERASE1_CYC    = fors_pkg::CYC_ERASE1,
    parameter int ERASEN_CYC    = fors_pkg::CYC_ERASEN,
    parameter int POR_WAIT_CYC  = fors_pkg::CYC_POR_WAIT
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // reset pin from the host
    input  wire logic        hw_reset_in_n,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // completion pin
    output logic             int_pin,
    output logic             int_pin_oe,
    // readiness
    output logic             boot_access_ok,
    output logic             cmd_ready
);

    ////////////////////////////////////////////////////////////////////////////
    localparam int TW = fors_pkg::TIMER_W;

    typedef struct packed {
        fors_pkg::fors_state_t st;
        logic [TW-1:0]         timer;
        logic                  int_flag;
        logic [2:0]            cfg;
        logic                  multi;
        logic                  boot_ok;
        logic                  cmd_ok;
        logic [15:0]           rdata;
        logic                  int_pin;
        logic                  int_oe;
    } fors_regs_t;

    fors_regs_t r_reg;
    fors_regs_t r_next;

    logic            cmd_wr;
    logic            hot_rst;
    logic            in_bootp;
    logic            op_start;
    logic [TW-1:0]   op_cycles;
    logic            op_valid;
    logic            op_erase;

    ////////////////////////////////////////////////////////////////////////////
    // command decode
    always_comb begin
        in_bootp = ((reg_addr >= fors_pkg::BOOTP_LO_BASE) && (reg_addr <= fors_pkg::BOOTP_LO_TOP))
                || ((reg_addr >= fors_pkg::BOOTP_HI_BASE) && (reg_addr <= fors_pkg::BOOTP_HI_TOP));
        cmd_wr  = reg_wr && (reg_addr == fors_pkg::ADDR_CMD);
        hot_rst = (cmd_wr && (reg_wdata == fors_pkg::CMD_RST_HOT))
               || (reg_wr && in_bootp && (reg_wdata == fors_pkg::CMD_RST_BP));
        op_valid  = 1'b1;
        op_erase  = 1'b0;
        op_cycles = '0;
        unique case (reg_wdata)
            fors_pkg::CMD_LOAD_SECT: op_cycles = TW'(fors_pkg::CYC_LOAD_SECT);
            fors_pkg::CMD_LOAD_PAGE: op_cycles = TW'(fors_pkg::CYC_LOAD_PAGE);
            fors_pkg::CMD_PROG_SECT: op_cycles = TW'(PROG_SECT_CYC);
            fors_pkg::CMD_PROG_PAGE: op_cycles = TW'(PROG_PAGE_CYC);
            fors_pkg::CMD_OTP:       op_cycles = TW'(fors_pkg::CYC_OTP);
            fors_pkg::CMD_LOCK:      op_cycles = TW'(fors_pkg::CYC_LOCK);
            fors_pkg::CMD_VERIFY:    op_cycles = TW'(fors_pkg::CYC_VERIFY);
            fors_pkg::CMD_BURST:     op_cycles = TW'(fors_pkg::CYC_INT_LOW);
            fors_pkg::CMD_ERASE1: begin
                op_cycles = TW'(ERASE1_CYC);
                op_erase  = 1'b1;
            end
            fors_pkg::CMD_ERASEN: begin
                op_cycles = TW'(ERASEN_CYC);
                op_erase  = 1'b1;
            end
            default: op_valid = 1'b0;
        endcase
        // operation commands only start once the reset sequence has signalled ready
        op_start = cmd_wr && op_valid && r_reg.cmd_ok && (r_reg.st == fors_pkg::ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_next = r_reg;
        if (r_reg.timer != '0) begin
            r_next.timer = r_reg.timer - TW'(1);
        end
        if (reg_wr && (reg_addr == fors_pkg::ADDR_CFG)) begin
            r_next.cfg = reg_wdata[2:0];
        end
        // host clear first; any hardware set below overrides it
        if (reg_wr && (reg_addr == fors_pkg::ADDR_INT) && !reg_wdata[0]) begin
            r_next.int_flag = 1'b0;
        end
        unique case (r_reg.st)
            fors_pkg::ST_POR_WAIT: begin
                if (r_reg.timer == '0) begin
                    r_next.st    = fors_pkg::ST_BOOT_COPY;
                    r_next.timer = TW'(fors_pkg::CYC_BOOT_COPY);
                end
            end
            fors_pkg::ST_BOOT_COPY: begin
                if (r_reg.timer == '0) begin
                    r_next.boot_ok = 1'b1;
                    // a pin still held low keeps the flag down until it rises
                    if (hw_reset_in_n) begin
                        r_next.st       = fors_pkg::ST_IDLE;
                        r_next.int_flag = 1'b1;
                        r_next.cmd_ok   = 1'b1;
                    end
                end
            end
            fors_pkg::ST_RESET: begin
                r_next.int_flag = 1'b0;
                if (!hw_reset_in_n) begin
                    r_next.timer = TW'(fors_pkg::CYC_READY2);
                end else if (r_reg.timer <= TW'(fors_pkg::CYC_READY2 - fors_pkg::CYC_READY1)) begin
                    r_next.boot_ok = 1'b1;
                end
                if (hw_reset_in_n && (r_reg.timer == '0)) begin
                    r_next.st       = fors_pkg::ST_IDLE;
                    r_next.int_flag = 1'b1;
                    r_next.cmd_ok   = 1'b1;
                end
            end
            fors_pkg::ST_IDLE: begin
                if (op_start) begin
                    r_next.st       = op_erase ? fors_pkg::ST_ERASE : fors_pkg::ST_OP;
                    r_next.timer    = op_cycles;
                    r_next.multi    = (reg_wdata == fors_pkg::CMD_ERASEN);
                    r_next.int_flag = 1'b0;
                end
            end
            fors_pkg::ST_OP: begin
                r_next.int_flag = 1'b0;
                if (r_reg.timer == '0) begin
                    r_next.st       = fors_pkg::ST_IDLE;
                    r_next.int_flag = 1'b1;
                end
            end
            fors_pkg::ST_ERASE: begin
                r_next.int_flag = 1'b0;
                if (cmd_wr && (reg_wdata == fors_pkg::CMD_SUSPEND)) begin
                    r_next.st    = fors_pkg::ST_SUSP_GO;
                    r_next.timer = TW'(SUSPEND_CYC);
                end else if (r_reg.timer == '0) begin
                    r_next.st       = fors_pkg::ST_IDLE;
                    r_next.int_flag = 1'b1;
                end
            end
            fors_pkg::ST_SUSP_GO: begin
                r_next.int_flag = 1'b0;
                if (r_reg.timer == '0) begin
                    r_next.st       = fors_pkg::ST_SUSPENDED;
                    r_next.int_flag = 1'b1;
                end
            end
            fors_pkg::ST_SUSPENDED: begin
                // the erase restarts its full time; simpler than tracking progress, still in budget
                if (cmd_wr && (reg_wdata == fors_pkg::CMD_RESUME)) begin
                    r_next.st       = fors_pkg::ST_ERASE;
                    r_next.timer    = r_reg.multi ? TW'(ERASEN_CYC) : TW'(ERASE1_CYC);
                    r_next.int_flag = 1'b0;
                end
            end
            default: begin
                r_next.st = fors_pkg::ST_IDLE;
            end
        endcase
        // warm or hot reset: registers to defaults, buffer contents untouched
        if ((hot_rst || !hw_reset_in_n) && (r_reg.st != fors_pkg::ST_POR_WAIT)
                && (r_reg.st != fors_pkg::ST_BOOT_COPY)) begin
            r_next.st       = fors_pkg::ST_RESET;
            r_next.timer    = TW'(fors_pkg::CYC_READY2);
            r_next.cfg      = fors_pkg::CFG_RESET;
            r_next.int_flag = 1'b0;
            r_next.boot_ok  = 1'b0;
            r_next.cmd_ok   = 1'b0;
            r_next.multi    = 1'b0;
        end
        // read data, one cycle after the strobe
        r_next.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                fors_pkg::ADDR_CFG: r_next.rdata = {13'h0000, r_reg.cfg};
                fors_pkg::ADDR_INT: r_next.rdata = {15'h0000, r_reg.int_flag};
                fors_pkg::ADDR_STATUS: begin
                    r_next.rdata[fors_pkg::STAT_INT_BIT]   = r_reg.int_flag;
                    r_next.rdata[fors_pkg::STAT_BUSY_BIT]  = (r_reg.st != fors_pkg::ST_IDLE)
                                                          && (r_reg.st != fors_pkg::ST_SUSPENDED);
                    r_next.rdata[fors_pkg::STAT_BOOT_BIT]  = r_reg.boot_ok;
                    r_next.rdata[fors_pkg::STAT_READY_BIT] = r_reg.cmd_ok;
                    r_next.rdata[fors_pkg::STAT_SUSP_BIT]  = (r_reg.st == fors_pkg::ST_SUSPENDED);
                end
                default: r_next.rdata = '0;
            endcase
        end
        r_next.int_pin = r_next.int_flag ~^ r_next.cfg[fors_pkg::CFG_POL_BIT];
        r_next.int_oe  = r_next.cfg[fors_pkg::CFG_OE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            r_reg          <= '0;
            r_reg.st       <= fors_pkg::ST_POR_WAIT;
            r_reg.timer    <= TW'(POR_WAIT_CYC);
            r_reg.cfg      <= fors_pkg::CFG_RESET;
            r_reg.int_pin  <= 1'b0;
            r_reg.int_oe   <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata      = r_reg.rdata;
    assign int_pin        = r_reg.int_pin;
    assign int_pin_oe     = r_reg.int_oe;
    assign boot_access_ok = r_reg.boot_ok;
    assign cmd_ready      = r_reg.cmd_ok;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    localparam int A_LD1  = fors_pkg::CYC_LOAD_SECT + 2;
    localparam int A_LD2  = fors_pkg::CYC_LOAD_PAGE + 2;
    localparam int A_OTP  = fors_pkg::CYC_OTP + 2;
    localparam int A_LOCK = fors_pkg::CYC_LOCK + 2;
    localparam int A_VER  = fors_pkg::CYC_VERIFY + 2;
    localparam int A_INTL = fors_pkg::CYC_INT_LOW + 2;
    localparam int A_RDY1 = fors_pkg::CYC_READY1 + 2;

    default clocking a_clk @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_start(logic [15:0] code);
        op_start && (reg_wdata == code);
    endsequence

    a_auto_int_low: assert property (op_start
        |=> !r_reg.int_flag ##0 (int_pin == !r_reg.cfg[fors_pkg::CFG_POL_BIT]))
        else $error("flag not low one cycle after command");
    a_sect_load_time: assert property (s_start(fors_pkg::CMD_LOAD_SECT)
        |=> !r_reg.int_flag ##[1:A_LD1] r_reg.int_flag)
        else $error("sector load overran");
    a_page_load_time: assert property (s_start(fors_pkg::CMD_LOAD_PAGE)
        |-> ##[2:A_LD2] r_reg.int_flag)
        else $error("page load overran");
    a_otp_time: assert property (s_start(fors_pkg::CMD_OTP) |-> ##[2:A_OTP] r_reg.int_flag)
        else $error("otp access overran");
    a_lock_op_time: assert property (s_start(fors_pkg::CMD_LOCK) |-> ##A_LOCK r_reg.int_flag)
        else $error("lock operation not done on time");
    a_verify_time: assert property (s_start(fors_pkg::CMD_VERIFY)
        |-> ##[2:A_VER] r_reg.int_flag)
        else $error("erase verify overran");
    a_burst_low: assert property (s_start(fors_pkg::CMD_BURST)
        |=> (!r_reg.int_flag)[*8] ##[1:A_INTL] r_reg.int_flag)
        else $error("burst gap wrong");
    a_busy_flag_low: assert property ((r_reg.st == fors_pkg::ST_OP
        || r_reg.st == fors_pkg::ST_ERASE || r_reg.st == fors_pkg::ST_SUSP_GO)
        |-> !r_reg.int_flag)
        else $error("flag high while busy");
    a_copy_done_flag: assert property ((r_reg.st == fors_pkg::ST_BOOT_COPY
        && r_reg.timer == '0) |=> (r_reg.int_flag == $past(hw_reset_in_n)))
        else $error("flag does not follow copy and pin");
    a_hot_reset_entry: assert property (hot_rst && r_reg.st == fors_pkg::ST_IDLE
        |=> r_reg.st == fors_pkg::ST_RESET && !cmd_ready && !boot_access_ok)
        else $error("reset command not taken");
    a_boot_ready_time: assert property (r_reg.st == fors_pkg::ST_RESET && hw_reset_in_n
        && !$past(hw_reset_in_n) |-> ##[1:A_RDY1] boot_access_ok)
        else $error("boot buffer not ready in time");
    a_reset_no_cmd: assert property (r_reg.st == fors_pkg::ST_RESET && cmd_wr
        |=> r_reg.st != fors_pkg::ST_OP && r_reg.st != fors_pkg::ST_ERASE)
        else $error("command accepted during reset");
    a_suspend_entry: assert property (r_reg.st == fors_pkg::ST_ERASE && cmd_wr
        && reg_wdata == fors_pkg::CMD_SUSPEND && hw_reset_in_n && !hot_rst
        |=> r_reg.st == fors_pkg::ST_SUSP_GO ##0 !r_reg.int_flag)
        else $error("suspend not started");

    c_boot_done:  cover property (r_reg.st == fors_pkg::ST_BOOT_COPY ##1 r_reg.st == fors_pkg::ST_IDLE);
    c_load_done:  cover property (s_start(fors_pkg::CMD_LOAD_SECT) ##[1:A_LD1] r_reg.int_flag);
    c_suspended:  cover property (r_reg.st == fors_pkg::ST_SUSPENDED);
    c_warm_reset: cover property (r_reg.st == fors_pkg::ST_RESET ##1 r_reg.st == fors_pkg::ST_IDLE);

endmodule

`default_nettype wire

// >>> verif/fors_host.sv
// host model: register port master and reset pin driver for the sequencer
// assumes the bench calls one task at a time, from the clock domain of the sequencer
`timescale 1ns/1ps
`default_nettype none

module fors_host (
    // clock
    input  wire logic        clock,
    // register port
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata,
    // reset pin, low at power-up
    output logic             hw_reset_in_n
);
    initial begin
        reg_addr      = 16'h0000;
        reg_wdata     = 16'h0000;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        hw_reset_in_n = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // released lines show the inverse so a stale value is never mistaken for data
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1 v = reg_rdata;
    endtask

    task automatic pin(input logic v);
        @(posedge clock);
        hw_reset_in_n <= v;
    endtask
endmodule

`default_nettype wire

// >>> verif/tb.sv
// testbench of the sequencer: boot, operation times, suspend, warm and hot resets
// assumes shortened long counts; short counts keep their full values
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int PS = 50, PP = 60, SU = 50, E1 = 80, EN = 100, POR = 50;
    logic        clock, reset_n, hw_reset_in_n, reg_wr, reg_rd;
    logic        int_pin, int_pin_oe, boot_access_ok, cmd_ready;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
    int          failures, checked, cyc, n;
    logic [15:0] ha [7] = '{16'hF220, 16'h01FF, 16'h800F, 16'h0000, 16'h8000, 16'h0200, 16'h8010};
    logic [15:0] hc [7] = '{16'h00F3, 16'h00F0, 16'h00F0, 16'h00F0, 16'h00F0, 16'h00F0, 16'h00F0};
    logic [6:0]  hx = 7'b0011111;

    fors_sequencer #(.PROG_SECT_CYC(PS), .PROG_PAGE_CYC(PP), .SUSPEND_CYC(SU),
        .ERASE1_CYC(E1), .ERASEN_CYC(EN), .POR_WAIT_CYC(POR)) fors_sequencer_i (
        .clock(clock), .reset_n(reset_n), .hw_reset_in_n(hw_reset_in_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .int_pin(int_pin), .int_pin_oe(int_pin_oe),
        .boot_access_ok(boot_access_ok), .cmd_ready(cmd_ready));
    fors_host host_i (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_reset_in_n(hw_reset_in_n));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    // k picks the signal: 0 boot access, 1 command ready, 2 completion pin
    task automatic till(input int k, input int lim);
        n = 0;
        while (((k == 0) ? boot_access_ok : (k == 1) ? cmd_ready : int_pin) !== 1'b1
               && n < lim) begin
            @(posedge clock);
            #1 n++;
        end
    endtask

    // max_ns of zero skips the absolute limit where the count is shortened
    task automatic op(input logic [15:0] c, input int exp, input int max_ns);
        host_i.wr(fors_pkg::ADDR_CMD, c);
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
            if (n == 1) chk(int_pin === 1'b0, "flag not dropped at command");
        end while (int_pin !== 1'b1 && n < exp + 20);
        // n counts from the edge that takes the strobe, one after the strobe is set
        chk(n + 1 == exp && (max_ns == 0 || n * 50 <= max_ns), "operation time");
        $display("test op %h done after %0d cycles", c, n);
    endtask

    task automatic hot(input logic [15:0] a, input logic [15:0] c, input logic x);
        host_i.wr(a, c);
        repeat (2) @(posedge clock);
        #1 chk(boot_access_ok === !x, "hot reset entry");
        till(1, 400);
        chk(boot_access_ok === 1'b1 && n <= 300, "hot reset exit");
        $display("test hot reset %h done", a);
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc = 0;
        failures = 0;
        checked = 0;
        reset_n = 1'b0;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        till(0, 3000);
        chk(n >= POR + 1400 && n <= POR + 1404, "boot copy timing");
        chk(int_pin === 1'b0 && cmd_ready === 1'b0, "ready with pin low");
        host_i.pin(1'b1);
        till(2, 4);
        chk(int_pin === 1'b1 && cmd_ready === 1'b1, "flag after pin high");
        chk(int_pin_oe === 1'b1, "completion output disabled");
        host_i.rd(fors_pkg::ADDR_CFG, d);
        chk(d[2:1] === 2'b11, "config default");
        host_i.rd(fors_pkg::ADDR_STATUS, d);
        chk(d[4:0] === 5'h0D, "status after boot");
        host_i.rd(16'h1234, d);
        chk(d === 16'h0000, "unmapped read");
        $display("test cold boot done");
        // auto mode on; commands only after ready, each page programmed once
        host_i.wr(fors_pkg::ADDR_CFG, 16'h0007);
        op(fors_pkg::CMD_LOAD_SECT, fors_pkg::CYC_LOAD_SECT + 2, 35000);
        op(fors_pkg::CMD_LOAD_PAGE, fors_pkg::CYC_LOAD_PAGE + 2, 45000);
        op(fors_pkg::CMD_PROG_SECT, PS + 2, 0);
        op(fors_pkg::CMD_PROG_PAGE, PP + 2, 0);
        op(fors_pkg::CMD_OTP, fors_pkg::CYC_OTP + 2, 700);
        op(fors_pkg::CMD_LOCK, fors_pkg::CYC_LOCK + 2, 700);
        op(fors_pkg::CMD_ERASE1, E1 + 2, 0);
        op(fors_pkg::CMD_ERASEN, EN + 2, 0);
        op(fors_pkg::CMD_VERIFY, fors_pkg::CYC_VERIFY + 2, 100000);
        op(fors_pkg::CMD_BURST, fors_pkg::CYC_INT_LOW + 2, 0);
        host_i.wr(fors_pkg::ADDR_CMD, fors_pkg::CMD_ERASE1);
        repeat (10) @(posedge clock);
        host_i.wr(fors_pkg::ADDR_CMD, fors_pkg::CMD_SUSPEND);
        n = 0;
        do begin
            host_i.rd(fors_pkg::ADDR_STATUS, d);
            n++;
        end while (d[4] !== 1'b1 && n < 60);
        chk(d[4] === 1'b1 && n * 2 <= SU + 6, "suspend time");
        op(fors_pkg::CMD_RESUME, E1 + 2, 0);
        host_i.wr(fors_pkg::ADDR_CFG, 16'h0003);
        repeat (2) @(posedge clock);
        #1 chk(int_pin_oe === 1'b0, "output enable follows config");
        host_i.pin(1'b0);
        repeat (4) @(posedge clock);
        host_i.pin(1'b1);
        till(0, 400);
        chk(n <= 102 && cmd_ready === 1'b0, "boot access after warm reset");
        host_i.wr(fors_pkg::ADDR_CMD, fors_pkg::CMD_LOAD_SECT);
        host_i.rd(fors_pkg::ADDR_STATUS, d);
        chk(d[3] === 1'b0 && d[1] === 1'b1, "reset not in progress");
        till(1, 400);
        host_i.rd(fors_pkg::ADDR_STATUS, d);
        chk(d[1] === 1'b0 && d[0] === 1'b1, "command taken before ready");
        host_i.rd(fors_pkg::ADDR_CFG, d);
        chk(d[2:0] === 3'b110 && int_pin_oe === 1'b1, "config after warm reset");
        $display("test warm reset done");
        for (int i = 0; i < 7; i++) hot(ha[i], hc[i], hx[i]);
        results();
    end
endmodule

`default_nettype wire
